// ===== core/bus_shared_gpio_ports.sv
// Purpose: gpio logic for two bus-shared ports and one bus-control port
// Assumes: mode is stable; pin inputs synchronous to core_clk
// Notes:   absent or unmapped registers answer slverr, read zero
// Overview of operation
// - data registers read and write any time while present in the map.
// - after reset every gpio pin is an input.
// - expanded modes: bus ports carry external address/data; else gpio.
// - expanded/peripheral modes remove bus port data and direction registers.
// - direction one makes output, zero input; resets to zero.
// - low bus port pull-ups follow enable on inputs; off in expanded.
// - high bus port pull-ups same, off in expanded mode only, not in peripheral.
// - each port's reduced-drive bit lowers that port's output drive.
// - reduced-drive register accepts only the first write after reset.
// - peripheral mode removes the reduced-drive register from the map.
// - control port bits 1:0 input-only, levels always readable.
// - function assignment overrides direction on control port pins.
// - only control port direction bits 7:2 take effect.
// - control port pull-up enable pulls up bits 7 and 3:0.
// - control regs absent in peripheral, or expanded with external map.
`timescale 1ns/1ps
module bus_shared_gpio_ports #(
    parameter int unsigned W = gpio_pkg::PORT_W
) (
    // clock, reset, enable
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    input  wire logic           ce,
    // operating mode
    input  wire logic [1:0]     op_mode,
    // axi4-lite write address
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_awaddr,
    // axi4-lite write data
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    // axi4-lite write response
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    output logic [1:0]          s_axi_bresp,
    // axi4-lite read
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    input  wire logic [31:0]    s_axi_araddr,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    // external bus controller, expanded modes
    input  wire logic [W-1:0]   ext_lo_out,
    input  wire logic [W-1:0]   ext_lo_oe,
    input  wire logic [W-1:0]   ext_hi_out,
    input  wire logic [W-1:0]   ext_hi_oe,
    // bus-control functions on control port
    input  wire logic [W-1:0]   ctrl_func_out,
    input  wire logic [W-1:0]   ctrl_func_oe,
    // low bus port pins
    input  wire logic [W-1:0]   lo_pin_in,
    output logic [W-1:0]        lo_pin_out,
    output logic [W-1:0]        lo_pin_oe,
    output logic [W-1:0]        lo_pullup,
    output logic                lo_low_drive,
    // high bus port pins
    input  wire logic [W-1:0]   hi_pin_in,
    output logic [W-1:0]        hi_pin_out,
    output logic [W-1:0]        hi_pin_oe,
    output logic [W-1:0]        hi_pullup,
    output logic                hi_low_drive,
    // control port pins
    input  wire logic [W-1:0]   ctrl_pin_in,
    output logic [W-1:0]        ctrl_pin_out,
    output logic [W-1:0]        ctrl_pin_oe,
    output logic [W-1:0]        ctrl_pullup,
    output logic                ctrl_low_drive
);
    localparam int unsigned AW = gpio_pkg::ADDR_W;
    // register state
    logic [W-1:0]  lo_data_q;
    logic [W-1:0]  hi_data_q;
    logic [W-1:0]  bus_port_lo_direction_q;
    logic [W-1:0]  bus_port_hi_direction_q;
    logic [W-1:0]  ctrl_data_q;
    logic [W-1:0]  ctrl_port_direction_q;
    logic [W-1:0]  ctrl_port_function_assign_q;
    logic [2:0]    pullup_control_q;
    logic [2:0]    reduced_drive_control_q;
    logic          low_drive_written_q;
    logic          ctrl_port_external_map_en_q;
    // axi state
    logic          aw_have_q;
    logic          w_have_q;
    logic [AW-1:0] waddr_q;
    logic [W-1:0]  wdata_q;
    logic          wstrb0_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;
    // mode decode
    logic          mode_single;
    logic          mode_periph;
    logic          mode_expanded;
    logic          bus_regs_present;
    logic          ctrl_regs_present;
    logic          low_drive_present;
    assign mode_single   = (op_mode == gpio_pkg::MODE_SINGLE);
    assign mode_periph   = (op_mode == gpio_pkg::MODE_PERIPHERAL);
    assign mode_expanded = (op_mode == gpio_pkg::MODE_EXPANDED);
    assign bus_regs_present  = mode_single;
    assign ctrl_regs_present = !mode_periph &&
                               !(mode_expanded && ctrl_port_external_map_en_q);
    assign low_drive_present = !mode_periph;
    // effective directions
    logic [W-1:0]  ctrl_gpio_dir;
    logic [W-1:0]  lo_read;
    logic [W-1:0]  hi_read;
    logic [W-1:0]  ctrl_read;
    assign ctrl_gpio_dir = ctrl_port_direction_q & gpio_pkg::CTRL_DIR_MASK
                         & ~ctrl_port_function_assign_q;
    assign lo_read   = (bus_port_lo_direction_q & lo_data_q)
                     | (~bus_port_lo_direction_q & lo_pin_in);
    assign hi_read   = (bus_port_hi_direction_q & hi_data_q)
                     | (~bus_port_hi_direction_q & hi_pin_in);
    assign ctrl_read = (ctrl_gpio_dir & ctrl_data_q)
                     | (~ctrl_gpio_dir & ctrl_pin_in);
    // address decode
    function automatic logic present(input logic [AW-1:0] a);
        unique case (a)
            gpio_pkg::OFF_LO_DATA, gpio_pkg::OFF_HI_DATA,
            gpio_pkg::OFF_LO_DIR, gpio_pkg::OFF_HI_DIR:      return bus_regs_present;
            gpio_pkg::OFF_CTRL_DATA, gpio_pkg::OFF_CTRL_DIR: return ctrl_regs_present;
            gpio_pkg::OFF_LOW_DRIVE:                         return low_drive_present;
            gpio_pkg::OFF_PULLUP, gpio_pkg::OFF_FUNC_ASSIGN,
            gpio_pkg::OFF_MAP_CTRL:                          return 1'b1;
            default:                                         return 1'b0;
        endcase
    endfunction
    // axi write path
    logic          wr_fire;
    logic          wr_ok;
    assign s_axi_awready = ce && !aw_have_q;
    assign s_axi_wready  = ce && !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire = ce && aw_have_q && w_have_q && !bvalid_q;
    always_comb wr_ok = wr_fire && present(waddr_q) && wstrb0_q;
    function automatic logic wr_sel(input logic [AW-1:0] off);
        return wr_ok && (waddr_q == off);
    endfunction
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            waddr_q   <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                waddr_q   <= s_axi_awaddr[AW-1:0];
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            w_have_q <= 1'b0;
            wdata_q  <= gpio_pkg::PORT_ZERO;
            wstrb0_q <= 1'b0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata[W-1:0];
                wstrb0_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= gpio_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= present(waddr_q) ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    // axi read path
    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    logic [W-1:0]  rd_mux;
    logic [AW-1:0] raddr;
    assign raddr = s_axi_araddr[AW-1:0];
    always_comb begin
        rd_mux = gpio_pkg::PORT_ZERO;
        unique case (raddr)
            gpio_pkg::OFF_LO_DATA:     rd_mux = lo_read;
            gpio_pkg::OFF_HI_DATA:     rd_mux = hi_read;
            gpio_pkg::OFF_LO_DIR:      rd_mux = bus_port_lo_direction_q;
            gpio_pkg::OFF_HI_DIR:      rd_mux = bus_port_hi_direction_q;
            gpio_pkg::OFF_CTRL_DATA:   rd_mux = ctrl_read;
            gpio_pkg::OFF_CTRL_DIR:    rd_mux = ctrl_port_direction_q;
            gpio_pkg::OFF_PULLUP:      rd_mux = {5'h00, pullup_control_q};
            gpio_pkg::OFF_LOW_DRIVE:   rd_mux = {5'h00, reduced_drive_control_q};
            gpio_pkg::OFF_FUNC_ASSIGN: rd_mux = ctrl_port_function_assign_q;
            gpio_pkg::OFF_MAP_CTRL:    rd_mux = {7'h00, ctrl_port_external_map_en_q};
            default:                   rd_mux = gpio_pkg::PORT_ZERO;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= gpio_pkg::RDATA_ZERO;
            rresp_q  <= gpio_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                if (present(raddr)) begin
                    rdata_q <= {24'h000000, rd_mux};
                    rresp_q <= gpio_pkg::RESP_OKAY;
                end else begin
                    rdata_q <= gpio_pkg::RDATA_ZERO;
                    rresp_q <= gpio_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    // port data registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lo_data_q   <= gpio_pkg::PORT_ZERO;
            hi_data_q   <= gpio_pkg::PORT_ZERO;
            ctrl_data_q <= gpio_pkg::PORT_ZERO;
        end else if (ce) begin
            if (wr_sel(gpio_pkg::OFF_LO_DATA)) lo_data_q <= wdata_q;
            if (wr_sel(gpio_pkg::OFF_HI_DATA)) hi_data_q <= wdata_q;
            if (wr_sel(gpio_pkg::OFF_CTRL_DATA)) ctrl_data_q <= wdata_q;
        end
    end
    // direction registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bus_port_lo_direction_q <= gpio_pkg::PORT_ZERO;
            bus_port_hi_direction_q <= gpio_pkg::PORT_ZERO;
            ctrl_port_direction_q   <= gpio_pkg::PORT_ZERO;
        end else if (ce) begin
            if (wr_sel(gpio_pkg::OFF_LO_DIR)) bus_port_lo_direction_q <= wdata_q;
            if (wr_sel(gpio_pkg::OFF_HI_DIR)) bus_port_hi_direction_q <= wdata_q;
            if (wr_sel(gpio_pkg::OFF_CTRL_DIR)) ctrl_port_direction_q <= wdata_q;
        end
    end
    // configuration registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pullup_control_q            <= gpio_pkg::CFG3_ZERO;
            ctrl_port_function_assign_q <= gpio_pkg::PORT_ZERO;
            ctrl_port_external_map_en_q <= 1'b0;
        end else if (ce) begin
            if (wr_sel(gpio_pkg::OFF_PULLUP)) pullup_control_q <= wdata_q[2:0];
            if (wr_sel(gpio_pkg::OFF_FUNC_ASSIGN)) ctrl_port_function_assign_q <= wdata_q;
            if (wr_sel(gpio_pkg::OFF_MAP_CTRL))
                ctrl_port_external_map_en_q <= wdata_q[gpio_pkg::BIT_EXT_MAP_EN];
        end
    end
    // write-once drive control
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reduced_drive_control_q <= gpio_pkg::CFG3_ZERO;
            low_drive_written_q     <= 1'b0;
        end else if (ce) begin
            if (wr_sel(gpio_pkg::OFF_LOW_DRIVE) && !low_drive_written_q) begin
                reduced_drive_control_q <= wdata_q[2:0];
                low_drive_written_q     <= 1'b1;
            end
        end
    end
    // pin drive, next values
    logic [W-1:0]  lo_out_d, lo_oe_d, lo_pu_d;
    logic [W-1:0]  hi_out_d, hi_oe_d, hi_pu_d;
    logic [W-1:0]  ctrl_out_d, ctrl_oe_d, ctrl_pu_d;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            // bus ports: external bus in expanded modes, gpio otherwise
            assign lo_out_d[i] = mode_single ? lo_data_q[i] : ext_lo_out[i];
            assign lo_oe_d[i]  = mode_single ? bus_port_lo_direction_q[i]
                                             : ext_lo_oe[i];
            assign hi_out_d[i] = mode_single ? hi_data_q[i] : ext_hi_out[i];
            assign hi_oe_d[i]  = mode_single ? bus_port_hi_direction_q[i]
                                             : ext_hi_oe[i];
            assign lo_pu_d[i]  = pullup_control_q[gpio_pkg::BIT_LO] && !mode_expanded
                               && !lo_oe_d[i];
            assign hi_pu_d[i]  = pullup_control_q[gpio_pkg::BIT_HI] && !mode_expanded
                               && !hi_oe_d[i];
            // control port: function assignment wins over direction
            assign ctrl_out_d[i] = ctrl_port_function_assign_q[i] ? ctrl_func_out[i]
                                                                  : ctrl_data_q[i];
            assign ctrl_oe_d[i]  = gpio_pkg::CTRL_DIR_MASK[i] &&
                                   (ctrl_port_function_assign_q[i] ? ctrl_func_oe[i]
                                                                   : ctrl_gpio_dir[i]);
            assign ctrl_pu_d[i]  = pullup_control_q[gpio_pkg::BIT_CTRL]
                                 && gpio_pkg::CTRL_PU_MASK[i] && !ctrl_oe_d[i];
        end
    endgenerate
    // registered pin outputs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lo_pin_out   <= gpio_pkg::PORT_ZERO;
            lo_pin_oe    <= gpio_pkg::PORT_ZERO;
            hi_pin_out   <= gpio_pkg::PORT_ZERO;
            hi_pin_oe    <= gpio_pkg::PORT_ZERO;
            ctrl_pin_out <= gpio_pkg::PORT_ZERO;
            ctrl_pin_oe  <= gpio_pkg::PORT_ZERO;
        end else if (ce) begin
            lo_pin_out   <= lo_out_d;
            lo_pin_oe    <= lo_oe_d;
            hi_pin_out   <= hi_out_d;
            hi_pin_oe    <= hi_oe_d;
            ctrl_pin_out <= ctrl_out_d;
            ctrl_pin_oe  <= ctrl_oe_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lo_pullup      <= gpio_pkg::PORT_ZERO;
            hi_pullup      <= gpio_pkg::PORT_ZERO;
            ctrl_pullup    <= gpio_pkg::PORT_ZERO;
            lo_low_drive   <= 1'b0;
            hi_low_drive   <= 1'b0;
            ctrl_low_drive <= 1'b0;
        end else if (ce) begin
            lo_pullup      <= lo_pu_d;
            hi_pullup      <= hi_pu_d;
            ctrl_pullup    <= ctrl_pu_d;
            lo_low_drive   <= reduced_drive_control_q[gpio_pkg::BIT_LO];
            hi_low_drive   <= reduced_drive_control_q[gpio_pkg::BIT_HI];
            ctrl_low_drive <= reduced_drive_control_q[gpio_pkg::BIT_CTRL];
        end
    end

endmodule // bus_shared_gpio_ports

// ===== include/gpio_pkg.sv
// Purpose: shared constants for the bus-shared gpio ports block
// Assumes: axi4-lite slave, 32-bit data, 8-bit registers in byte lane 0
// Notes:   offsets are byte addresses
package gpio_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned PORT_W = 8;
    // register offsets
    localparam logic [5:0] OFF_LO_DATA     = 6'h00;
    localparam logic [5:0] OFF_HI_DATA     = 6'h04;
    localparam logic [5:0] OFF_LO_DIR      = 6'h08;
    localparam logic [5:0] OFF_HI_DIR      = 6'h0C;
    localparam logic [5:0] OFF_CTRL_DATA   = 6'h10;
    localparam logic [5:0] OFF_CTRL_DIR    = 6'h14;
    localparam logic [5:0] OFF_PULLUP      = 6'h18;
    localparam logic [5:0] OFF_LOW_DRIVE   = 6'h1C;
    localparam logic [5:0] OFF_FUNC_ASSIGN = 6'h20;
    localparam logic [5:0] OFF_MAP_CTRL    = 6'h24;
    // field positions in pullup_control and reduced_drive_control
    localparam int unsigned BIT_LO   = 0;
    localparam int unsigned BIT_HI   = 1;
    localparam int unsigned BIT_CTRL = 2;
    // field position in map control
    localparam int unsigned BIT_EXT_MAP_EN = 0;
    // masks
    localparam logic [7:0] CTRL_DIR_MASK   = 8'hFC;
    localparam logic [7:0] CTRL_PU_MASK    = 8'h8F;
    localparam logic [7:0] PORT_ZERO       = 8'h00;
    localparam logic [2:0] CFG3_ZERO       = 3'h0;
    localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
    // operating modes
    localparam logic [1:0] MODE_SINGLE     = 2'h0;
    localparam logic [1:0] MODE_EXPANDED   = 2'h1;
    localparam logic [1:0] MODE_PERIPHERAL = 2'h2;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== testbench/gpio_port_assertions.sv
// Purpose: port checks for the bus-shared gpio ports
// Assumes: one clock, sync active-low reset
// Notes:   bound onto the top module
`timescale 1ns/1ps
module gpio_port_checker #(
    parameter int unsigned W = 8
) (
    // clock, reset, mode
    input wire logic         core_clk,
    input wire logic         reset_n,
    input wire logic         ce,
    input wire logic [1:0]   op_mode,
    // register read channel
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_araddr,
    input wire logic         s_axi_rvalid,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic [1:0]   s_axi_rresp,
    // pins
    input wire logic [W-1:0] ext_lo_out,
    input wire logic [W-1:0] ext_lo_oe,
    input wire logic [W-1:0] lo_pin_out,
    input wire logic [W-1:0] lo_pin_oe,
    input wire logic [W-1:0] lo_pullup,
    input wire logic [W-1:0] hi_pin_oe,
    input wire logic [W-1:0] hi_pullup,
    input wire logic [W-1:0] ctrl_pin_oe,
    input wire logic [W-1:0] ctrl_pullup
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    reset_inputs_a: assert property ($rose(reset_n) |-> (lo_pin_oe | hi_pin_oe | ctrl_pin_oe) == 8'h00)
        else $error("pin driven right after reset");
    ext_follow_a: assert property ($past(reset_n) && $past(ce) && $past(op_mode) == gpio_pkg::MODE_EXPANDED
        |-> lo_pin_oe == $past(ext_lo_oe) && lo_pin_out == $past(ext_lo_out))
        else $error("bus port not handed to external bus");
    bus_pullup_off_a: assert property ($past(ce) && $past(op_mode) == gpio_pkg::MODE_EXPANDED
        |-> (lo_pullup | hi_pullup) == 8'h00) else $error("bus port pull-up in expanded mode");
    ctrl_pullup_set_a: assert property ((ctrl_pullup & ~gpio_pkg::CTRL_PU_MASK) == 8'h00)
        else $error("control port pull-up on bits 6:4");
    pullup_input_a: assert property ((lo_pullup & lo_pin_oe) == 8'h00 && (hi_pullup & hi_pin_oe) == 8'h00)
        else $error("pull-up on driving pin");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && s_axi_rdata[31:8] == 24'h000000) else $error("read answer late or wide");
    bus_absent_a: assert property (s_axi_arvalid && s_axi_arready && op_mode != gpio_pkg::MODE_SINGLE
        && s_axi_araddr[5:0] == gpio_pkg::OFF_LO_DATA |=> s_axi_rresp == gpio_pkg::RESP_SLVERR)
        else $error("bus port data present outside single-chip");
    drive_absent_a: assert property (s_axi_arvalid && s_axi_arready && op_mode == gpio_pkg::MODE_PERIPHERAL
        && s_axi_araddr[5:0] == gpio_pkg::OFF_LOW_DRIVE |=> s_axi_rresp == gpio_pkg::RESP_SLVERR)
        else $error("drive control present in peripheral mode");
endmodule // gpio_port_checker

bind bus_shared_gpio_ports gpio_port_checker #(.W(W)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .ce(ce), .op_mode(op_mode),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .ext_lo_out(ext_lo_out), .ext_lo_oe(ext_lo_oe), .lo_pin_out(lo_pin_out),
    .lo_pin_oe(lo_pin_oe), .lo_pullup(lo_pullup), .hi_pin_oe(hi_pin_oe),
    .hi_pullup(hi_pullup), .ctrl_pin_oe(ctrl_pin_oe), .ctrl_pullup(ctrl_pullup)
);

// ===== testbench/bus_shared_gpio_ports_tb.sv
// Purpose: self-checking bench for the bus-shared gpio ports
// Assumes: 40 MHz core_clk, sync active-low reset
// Notes:   master looks at ready at the falling edge, acts after the rising one
`timescale 1ns/1ps
module bus_shared_gpio_ports_tb;
    logic        core_clk, reset_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, lo_low_drive, hi_low_drive, ctrl_low_drive;
    logic [1:0]  op_mode, s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [7:0]  ext_lo_out, ext_lo_oe, ext_hi_out, ext_hi_oe, ctrl_func_out, ctrl_func_oe;
    logic [7:0]  lo_pin_in, lo_pin_out, lo_pin_oe, lo_pullup, hi_pin_in, hi_pin_out, hi_pin_oe;
    logic [7:0]  hi_pullup, ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe, ctrl_pullup;
    int          fail_count = 0;
    int          checks = 0;

    bus_shared_gpio_ports uut (
        .core_clk(core_clk), .reset_n(reset_n), .ce(ce), .op_mode(op_mode),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .ext_lo_out(ext_lo_out),
        .ext_lo_oe(ext_lo_oe), .ext_hi_out(ext_hi_out), .ext_hi_oe(ext_hi_oe),
        .ctrl_func_out(ctrl_func_out), .ctrl_func_oe(ctrl_func_oe), .lo_pin_in(lo_pin_in),
        .lo_pin_out(lo_pin_out), .lo_pin_oe(lo_pin_oe), .lo_pullup(lo_pullup),
        .lo_low_drive(lo_low_drive), .hi_pin_in(hi_pin_in), .hi_pin_out(hi_pin_out),
        .hi_pin_oe(hi_pin_oe), .hi_pullup(hi_pullup), .hi_low_drive(hi_low_drive),
        .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe),
        .ctrl_pullup(ctrl_pullup), .ctrl_low_drive(ctrl_low_drive)
    );

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        logic pa, pw, got;
        {pa, pw, got} = 3'h6;
        @(posedge core_clk);
        s_axi_awaddr <= {26'h0, a};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!got) begin
            @(negedge core_clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            got = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        s_axi_bready <= 1'h0;
    endtask

    task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] d,
                        input logic [1:0] r);
        logic pa, got;
        logic [9:0] v;
        {pa, got} = 2'h2;
        @(posedge core_clk);
        s_axi_araddr <= {26'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!got) begin
            @(negedge core_clk);
            pa = pa && !s_axi_arready;
            got = s_axi_rvalid;
            v = {s_axi_rresp, s_axi_rdata[7:0]};
            @(posedge core_clk);
            s_axi_arvalid <= pa;
        end
        s_axi_rready <= 1'h0;
        chk(n, v, {r, d});
    endtask

    task automatic wchk(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
        logic [1:0] rr;
        wr(a, d, rr);
        chk("write resp", rr, r);
    endtask

    task automatic settle;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic t_reset;
        @(negedge core_clk);
        chk("reset oe", {lo_pin_oe, hi_pin_oe, ctrl_pin_oe}, 24'h0);
        rchk("lo dir", gpio_pkg::OFF_LO_DIR, 8'h00, gpio_pkg::RESP_OKAY);
        rchk("unmapped", 6'h28, 8'h00, gpio_pkg::RESP_SLVERR);
    endtask

    task automatic t_ports;
        @(posedge core_clk);
        lo_pin_in <= 8'h3C;
        hi_pin_in <= 8'h96;
        wchk(gpio_pkg::OFF_LO_DIR, 8'hF0, gpio_pkg::RESP_OKAY);
        wchk(gpio_pkg::OFF_LO_DATA, 8'hA5, gpio_pkg::RESP_OKAY);
        wchk(gpio_pkg::OFF_PULLUP, 8'h07, gpio_pkg::RESP_OKAY);
        settle();
        chk("lo oe", lo_pin_oe, 8'hF0);
        chk("lo out", lo_pin_out & 8'hF0, 8'hA0);
        chk("pullups", {lo_pullup, hi_pullup, ctrl_pullup}, 24'h0FFF8F);
        rchk("lo data", gpio_pkg::OFF_LO_DATA, 8'hAC, gpio_pkg::RESP_OKAY);
        rchk("hi data", gpio_pkg::OFF_HI_DATA, 8'h96, gpio_pkg::RESP_OKAY);
    endtask

    task automatic t_ctrl;
        @(posedge core_clk);
        ctrl_pin_in <= 8'h03;
        ctrl_func_oe <= 8'h10;
        wchk(gpio_pkg::OFF_CTRL_DIR, 8'hFF, gpio_pkg::RESP_OKAY);
        wchk(gpio_pkg::OFF_FUNC_ASSIGN, 8'h30, gpio_pkg::RESP_OKAY);
        wchk(gpio_pkg::OFF_CTRL_DATA, 8'hFF, gpio_pkg::RESP_OKAY);
        settle();
        chk("ctrl oe", ctrl_pin_oe, 8'hDC);
        chk("ctrl out", ctrl_pin_out & 8'hFC, 8'hCC);
        chk("ctrl pullup", ctrl_pullup, 8'h03);
        rchk("ctrl data", gpio_pkg::OFF_CTRL_DATA, 8'hCF, gpio_pkg::RESP_OKAY);
    endtask

    task automatic t_drive;
        wchk(gpio_pkg::OFF_LOW_DRIVE, 8'h05, gpio_pkg::RESP_OKAY);
        settle();
        chk("low drive", {lo_low_drive, hi_low_drive, ctrl_low_drive}, 3'h5);
        wchk(gpio_pkg::OFF_LOW_DRIVE, 8'h02, gpio_pkg::RESP_OKAY);
        settle();
        chk("drive kept", {lo_low_drive, hi_low_drive, ctrl_low_drive}, 3'h5);
        rchk("drive reg", gpio_pkg::OFF_LOW_DRIVE, 8'h05, gpio_pkg::RESP_OKAY);
    endtask

    task automatic t_modes;
        @(posedge core_clk);
        op_mode <= gpio_pkg::MODE_EXPANDED;
        {ext_lo_oe, ext_lo_out, ext_hi_oe, ext_hi_out} <= 32'h5AC3A53C;
        settle();
        chk("ext pins", {lo_pin_oe, lo_pin_out, hi_pin_oe, hi_pin_out}, 32'h5AC3A53C);
        chk("exp pullup", {lo_pullup, hi_pullup}, 16'h0);
        rchk("exp lo data", gpio_pkg::OFF_LO_DATA, 8'h00, gpio_pkg::RESP_SLVERR);
        rchk("exp hi dir", gpio_pkg::OFF_HI_DIR, 8'h00, gpio_pkg::RESP_SLVERR);
        wchk(gpio_pkg::OFF_LO_DIR, 8'h00, gpio_pkg::RESP_SLVERR);
        rchk("exp ctrl", gpio_pkg::OFF_CTRL_DATA, 8'hCF, gpio_pkg::RESP_OKAY);
        wchk(gpio_pkg::OFF_MAP_CTRL, 8'h01, gpio_pkg::RESP_OKAY);
        rchk("ext map dir", gpio_pkg::OFF_CTRL_DIR, 8'h00, gpio_pkg::RESP_SLVERR);
        @(posedge core_clk);
        op_mode <= gpio_pkg::MODE_PERIPHERAL;
        rchk("per drive", gpio_pkg::OFF_LOW_DRIVE, 8'h00, gpio_pkg::RESP_SLVERR);
        rchk("per ctrl", gpio_pkg::OFF_CTRL_DATA, 8'h00, gpio_pkg::RESP_SLVERR);
    endtask

    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {ext_lo_out, ext_lo_oe, ext_hi_out, ext_hi_oe, ctrl_func_out, ctrl_func_oe} = 48'h0;
        {lo_pin_in, hi_pin_in, ctrl_pin_in} = 24'h000000;
        ce = 1'h1;
        s_axi_wstrb = 4'h1;
        op_mode = gpio_pkg::MODE_SINGLE;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'h1;
        t_reset();
        t_ports();
        t_ctrl();
        t_drive();
        t_modes();
        close_out();
    end

    initial begin
        #50us;
        fail_count++;
        close_out();
    end
endmodule // bus_shared_gpio_ports_tb
